// File: rtl/gis_pkg.sv
// constants for the gpio interrupt status, function select and drive block
// assumes an apb slave with 32-bit data and byte addresses
`default_nettype none
package gis_pkg;
    localparam int unsigned GIS_PINS = 8;
    localparam logic [11:0] GIS_OFS_MSK_STAT = 12'h418;
    localparam logic [11:0] GIS_OFS_ICR = 12'h41c;
    localparam logic [11:0] GIS_OFS_FSEL = 12'h420;
    localparam logic [11:0] GIS_OFS_DRV_LOW = 12'h500;
    localparam logic [11:0] GIS_OFS_DRV_MID = 12'h504;
    localparam logic [11:0] GIS_OFS_DRV_HIGH = 12'h508;
    // registers for fields the block needs but that carry no printed offset
    localparam logic [11:0] GIS_OFS_RIS = 12'h414;
    localparam logic [11:0] GIS_OFS_MASK = 12'h410;
    localparam logic [11:0] GIS_OFS_SENSE = 12'h404;
    localparam logic [11:0] GIS_OFS_BOTH = 12'h408;
    localparam logic [11:0] GIS_OFS_EVENT = 12'h40c;
    localparam logic [11:0] GIS_OFS_DIR = 12'h400;
    localparam logic [7:0] GIS_RST_ZERO = 8'h00;
    localparam logic [7:0] GIS_RST_DRV_LOW = 8'hff;
    localparam logic [7:0] GIS_RST_FSEL_B = 8'h80;
    localparam logic [7:0] GIS_RST_FSEL_C = 8'h0f;
    localparam logic [1:0] GIS_PORT_PLAIN = 2'h0;
    localparam logic [1:0] GIS_PORT_B = 2'h1;
    localparam logic [1:0] GIS_PORT_C = 2'h2;
endpackage
`default_nettype wire

// File: rtl/gis_irq_detect.sv
// per-pin trigger detection with latched edge status and clear
// assumes pins are already synchronised to clock_in
`default_nettype none
module gis_irq_detect (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic [7:0] pins_in,
    input wire logic [7:0] sense_in,
    input wire logic [7:0] both_in,
    input wire logic [7:0] event_in,
    input wire logic [7:0] clear_in,
    output logic [7:0] raw_out
);
    typedef struct packed {
        logic [7:0] prev;
        logic [7:0] edge_seen;
    } gis_det_s;
    gis_det_s st_ff;
    gis_det_s nxt_st;
    logic [7:0] hit;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            // level pins follow the pin directly; edge pins latch
            assign hit[g] = both_in[g] ? (pins_in[g] ^ st_ff.prev[g]) :
                (event_in[g] ? (pins_in[g] & ~st_ff.prev[g]) :
                (~pins_in[g] & st_ff.prev[g]));
            assign raw_out[g] = sense_in[g] ? (pins_in[g] == event_in[g]) :
                st_ff.edge_seen[g];
        end
    endgenerate
    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev = pins_in;
        // new edge wins over a clear in the same cycle
        nxt_st.edge_seen = (st_ff.edge_seen & ~clear_in) | (hit & ~sense_in);
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else if (enable_in) begin
            st_ff <= nxt_st;
        end
    end
    AST_CLEAR_DROPS: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        enable_in && |clear_in
        |=> (st_ff.edge_seen & $past(clear_in) & ~$past(hit)) == 8'h00)
        else $error("edge status survived a clear");
endmodule
`default_nettype wire

// File: rtl/gis_drive_sel.sv
// three exclusive drive strength selects with delayed cross clearing
// assumes write strobes are one cycle and qualified by the apb access phase
`default_nettype none
module gis_drive_sel (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic [2:0] wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] low_drive_bits_out,
    output logic [7:0] mid_drive_bits_out,
    output logic [7:0] high_drive_bits_out
);
    typedef struct packed {
        logic [2:0][7:0] drv;
        logic [2:0][7:0] pend;
    } gis_drv_s;
    gis_drv_s st_ff;
    gis_drv_s nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pend = '0;
        for (int i = 0; i < 3; i++) begin
            // clearing is staged one cycle so it lands on the second edge
            nxt_st.drv[i] = st_ff.drv[i] & ~st_ff.pend[i];
            if (wr_in[i]) begin
                nxt_st.drv[i] = wdata_in;
            end
            for (int j = 0; j < 3; j++) begin
                if (wr_in[j] && j != i) begin
                    nxt_st.pend[i] = nxt_st.pend[i] | wdata_in;
                end
            end
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff.drv[0] <= gis_pkg::GIS_RST_DRV_LOW;
            st_ff.drv[1] <= gis_pkg::GIS_RST_ZERO;
            st_ff.drv[2] <= gis_pkg::GIS_RST_ZERO;
            st_ff.pend <= '0;
        end else if (enable_in) begin
            st_ff <= nxt_st;
        end
    end
    assign low_drive_bits_out = st_ff.drv[0];
    assign mid_drive_bits_out = st_ff.drv[1];
    assign high_drive_bits_out = st_ff.drv[2];
    AST_MID_CLEARS_LOW: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        enable_in && wr_in == 3'h2 && wdata_in[0] ##1 enable_in && wr_in == 3'h0
        |=> !st_ff.drv[0][0])
        else $error("low drive not cleared two cycles after mid write");
    AST_HIGH_CLEARS_MID: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        enable_in && wr_in == 3'h4 && wdata_in[1] ##1 enable_in && wr_in == 3'h0
        |=> !st_ff.drv[1][1] && !st_ff.drv[0][1])
        else $error("mid or low drive not cleared after high write");
    AST_LOW_CLEARS_HIGH: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        enable_in && wr_in == 3'h1 && wdata_in[2] ##1 enable_in && wr_in == 3'h0
        |=> !st_ff.drv[2][2] && !st_ff.drv[1][2])
        else $error("high or mid drive not cleared after low write");
    AST_CLEAR_NOT_EARLY: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        enable_in && wr_in == 3'h2 && wdata_in[3] && st_ff.drv[0][3] && !st_ff.pend[0][3]
        |=> st_ff.drv[0][3])
        else $error("cross clear visible one cycle early");
endmodule
`default_nettype wire

// File: rtl/gis_top.sv
// gpio port slice: interrupt status and clear, function select, drive select
// assumes an apb master on clock_in; pins arrive asynchronously
// Summary of operation
// - masked status bit is raw status and mask bit together, zero after reset.
// - writing one to a clear bit drops that pin's latched edge; zero leaves it alone.
// - a function select bit of one gives the pin to its hardware function.
// - function select resets to zero, or 0x80 on port b, or 0x0f on port c.
// - any reset returns direction and function select to their defaults.
// - setting a low drive bit clears that pin's mid and high drive bits.
// - setting a mid drive bit clears that pin's low and high drive bits.
// - setting a high drive bit clears that pin's low and mid drive bits.
// - the cross clearing of drive bits shows on the second cycle after the write.
// - after reset all pins use low drive, fields 0xff, 0x00 and 0x00.
// - a set mask bit lets the pin drive its own and the combined interrupt.
// - raw status shows a met trigger before masking and resets to zero.
`default_nettype none
module gis_top #(
    parameter logic [1:0] PORT_KIND = gis_pkg::GIS_PORT_PLAIN
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [7:0] pins_in,
    input wire logic [7:0] sw_out_data_in,
    input wire logic [7:0] hw_out_data_in,
    input wire logic [7:0] hw_out_en_in,
    output logic [7:0] pin_data_out,
    output logic [7:0] pin_oe_n_out,
    output logic [7:0] function_select_out,
    output logic [7:0] pin_direction_out,
    output logic [7:0] low_drive_bits_out,
    output logic [7:0] mid_drive_bits_out,
    output logic [7:0] high_drive_bits_out,
    output logic [7:0] pin_irq_out,
    output logic combined_port_irq_out
);
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] fsel;
        logic [7:0] dir;
        logic [7:0] mask;
        logic [7:0] sense;
        logic [7:0] both;
        logic [7:0] evt;
        logic [7:0] pdata;
    } gis_top_s;

    // debug pins come back on every reset, so only the instance kind matters
    localparam logic [7:0] FSEL_RST = (PORT_KIND == gis_pkg::GIS_PORT_B) ?
        gis_pkg::GIS_RST_FSEL_B : (PORT_KIND == gis_pkg::GIS_PORT_C) ?
        gis_pkg::GIS_RST_FSEL_C : gis_pkg::GIS_RST_ZERO;

    gis_top_s st_ff;
    gis_top_s nxt_st;
    logic wr_en;
    logic rd_en;
    logic [7:0] raw_irq_status;
    logic [7:0] masked_status_field;
    logic [7:0] clear_field;
    logic [2:0] drv_wr;
    logic [7:0] rd_byte;
    logic hit;

    assign wr_en = psel_in & penable_in & pwrite_in & clk_en_in;
    assign rd_en = psel_in & ~pwrite_in;
    // no wait states; freezing the clock enable also holds off completion
    assign pready_out = clk_en_in;
    assign pslverr_out = 1'b0;

    assign clear_field = (wr_en && paddr_in == gis_pkg::GIS_OFS_ICR) ?
        pwdata_in[7:0] : 8'h00;
    assign drv_wr[0] = wr_en && paddr_in == gis_pkg::GIS_OFS_DRV_LOW;
    assign drv_wr[1] = wr_en && paddr_in == gis_pkg::GIS_OFS_DRV_MID;
    assign drv_wr[2] = wr_en && paddr_in == gis_pkg::GIS_OFS_DRV_HIGH;

    gis_irq_detect u_detect (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(clk_en_in),
        .pins_in(st_ff.sync2),
        .sense_in(st_ff.sense),
        .both_in(st_ff.both),
        .event_in(st_ff.evt),
        .clear_in(clear_field),
        .raw_out(raw_irq_status)
    );

    gis_drive_sel u_drive (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(clk_en_in),
        .wr_in(drv_wr),
        .wdata_in(pwdata_in[7:0]),
        .low_drive_bits_out(low_drive_bits_out),
        .mid_drive_bits_out(mid_drive_bits_out),
        .high_drive_bits_out(high_drive_bits_out)
    );

    assign masked_status_field = raw_irq_status & st_ff.mask;
    assign pin_irq_out = masked_status_field;
    assign combined_port_irq_out = |masked_status_field;

    always_comb begin
        hit = 1'b1;
        unique case (paddr_in)
            gis_pkg::GIS_OFS_MSK_STAT: rd_byte = masked_status_field;
            gis_pkg::GIS_OFS_RIS: rd_byte = raw_irq_status;
            gis_pkg::GIS_OFS_FSEL: rd_byte = st_ff.fsel;
            gis_pkg::GIS_OFS_DRV_LOW: rd_byte = low_drive_bits_out;
            gis_pkg::GIS_OFS_DRV_MID: rd_byte = mid_drive_bits_out;
            gis_pkg::GIS_OFS_DRV_HIGH: rd_byte = high_drive_bits_out;
            gis_pkg::GIS_OFS_MASK: rd_byte = st_ff.mask;
            gis_pkg::GIS_OFS_SENSE: rd_byte = st_ff.sense;
            gis_pkg::GIS_OFS_BOTH: rd_byte = st_ff.both;
            gis_pkg::GIS_OFS_EVENT: rd_byte = st_ff.evt;
            gis_pkg::GIS_OFS_DIR: rd_byte = st_ff.dir;
            default: begin
                rd_byte = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = pins_in;
        nxt_st.sync2 = st_ff.sync1;
        if (wr_en) begin
            unique case (paddr_in)
                gis_pkg::GIS_OFS_FSEL: nxt_st.fsel = pwdata_in[7:0];
                gis_pkg::GIS_OFS_MASK: nxt_st.mask = pwdata_in[7:0];
                gis_pkg::GIS_OFS_SENSE: nxt_st.sense = pwdata_in[7:0];
                gis_pkg::GIS_OFS_BOTH: nxt_st.both = pwdata_in[7:0];
                gis_pkg::GIS_OFS_EVENT: nxt_st.evt = pwdata_in[7:0];
                gis_pkg::GIS_OFS_DIR: nxt_st.dir = pwdata_in[7:0];
                default: nxt_st = nxt_st;
            endcase
        end
        // read data is registered during setup so prdata comes from a flop
        nxt_st.pdata = (rd_en && !penable_in) ? (hit ? rd_byte : 8'h00) : st_ff.pdata;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.fsel <= FSEL_RST;
            st_ff.dir <= gis_pkg::GIS_RST_ZERO;
        end else if (clk_en_in) begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_out = {24'h000000, st_ff.pdata};
    assign function_select_out = st_ff.fsel;
    assign pin_direction_out = st_ff.dir;
    // hardware owns the pin where selected; debug pins start that way
    generate
        for (genvar g = 0; g < 8; g++) begin : g_mux
            assign pin_data_out[g] = st_ff.fsel[g] ? hw_out_data_in[g] :
                sw_out_data_in[g];
            assign pin_oe_n_out[g] = st_ff.fsel[g] ? ~hw_out_en_in[g] :
                ~st_ff.dir[g];
        end
    endgenerate

    AST_MSK_IS_RAW_AND_MASK: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        combined_port_irq_out == |(raw_irq_status & st_ff.mask))
        else $error("masked status disagrees with raw and mask");
    AST_MSK_READ: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        clk_en_in && psel_in && !penable_in && !pwrite_in
        && paddr_in == gis_pkg::GIS_OFS_MSK_STAT
        |=> prdata_out[7:0] == ($past(raw_irq_status) & $past(st_ff.mask)))
        else $error("masked status read back wrong");
    AST_FSEL_WRITE: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        wr_en && paddr_in == gis_pkg::GIS_OFS_FSEL
        |=> function_select_out == $past(pwdata_in[7:0]))
        else $error("function select not written");
    AST_FSEL_HW_PIN: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        st_ff.fsel[0] |-> pin_data_out[0] == hw_out_data_in[0])
        else $error("selected pin not given to hardware");
    AST_IRQ_MASKED_OFF: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        st_ff.mask == 8'h00 |-> !combined_port_irq_out && pin_irq_out == 8'h00)
        else $error("interrupt raised while fully masked");
    AST_RST_DEFAULTS: assert property (@(posedge clock_in)
        $rose(rst_n_in) |-> function_select_out == FSEL_RST
        && pin_direction_out == 8'h00 && low_drive_bits_out == 8'hff)
        else $error("defaults wrong after reset");
endmodule
`default_nettype wire

// File: sim/gis_pin_model.sv
// partner model: board pin levels and an on-chip hardware function
// assumes the bench commands pin levels; the hardware side free-runs
`default_nettype none
module gis_pin_model (
    input wire logic clock_in,
    input wire logic [7:0] level_in,
    output logic [7:0] pins_out,
    output var logic [7:0] hw_data_out,
    output var logic [7:0] hw_en_out
);
    timeunit 1ns;
    timeprecision 100ps;
    assign pins_out = level_in;
    // hardware drive changes every cycle so a stale mux shows
    initial begin
        hw_data_out = 8'h3c;
        hw_en_out = 8'ha5;
        forever begin
            @(posedge clock_in);
            hw_data_out <= hw_data_out + 8'h5b;
            hw_en_out <= ~hw_en_out;
        end
    end
endmodule
`default_nettype wire

// File: sim/gis_irq_status_altfunc_drive_tb_top.sv
// self-checking bench for the port b slice: status, clear, function and drive
// assumes apb completes when pready is seen; pins come from the partner model
`default_nettype none
module gis_irq_status_altfunc_drive_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in, rst_n_in, en, psel, penable, pwrite, pready, pslverr, err, cirq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] level, pins, sw, hwd, hwe, pdo, poe, fsel, dir, pirq, lo, mi, hi, d;
    logic [2:0][7:0] ex, mid;
    int n_errors = 0;
    int n_tests = 0;
    int k, b, c;
    gis_top #(.PORT_KIND(gis_pkg::GIS_PORT_B)) u_dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(en),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .pins_in(pins), .sw_out_data_in(sw),
        .hw_out_data_in(hwd), .hw_out_en_in(hwe), .pin_data_out(pdo),
        .pin_oe_n_out(poe), .function_select_out(fsel), .pin_direction_out(dir),
        .low_drive_bits_out(lo), .mid_drive_bits_out(mi), .high_drive_bits_out(hi),
        .pin_irq_out(pirq), .combined_port_irq_out(cirq));
    gis_pin_model u_pins (.clock_in(clock_in), .level_in(level), .pins_out(pins),
        .hw_data_out(hwd), .hw_en_out(hwe));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        // only the watchdog ends a wait on a slave that never answers
        do @(posedge clock_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    function automatic logic [2:0][7:0] drv_next(input logic [2:0][7:0] cur, input int w,
                                                 input logic [7:0] v);
        drv_next = cur;
        for (int j = 0; j < 3; j++)
            drv_next[j] = (j == w) ? v : cur[j] & ~v;
    endfunction
    task automatic give_verdict;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        give_verdict();
    end
    initial begin
        {rst_n_in, psel, penable, pwrite, paddr, pwdata, level, sw} = '0;
        en = 1'b1;
        void'($urandom(79));
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rdchk(gis_pkg::GIS_OFS_FSEL, 32'h80);
        rdchk(gis_pkg::GIS_OFS_MSK_STAT, 32'h0);
        rdchk(gis_pkg::GIS_OFS_RIS, 32'h0);
        rdchk(12'hffc, 32'h0);
        chk({31'h0, err}, 32'h0);
        ex = {8'h00, 8'h00, 8'hff};
        for (int j = 0; j < 3; j++)
            rdchk(gis_pkg::GIS_OFS_DRV_LOW + 12'(4 * j), {24'h0, ex[j]});
        done("reset");
        // drive selects: random field and data, full and empty first
        // the third write is followed by a clock-enable freeze that must hold the clear off
        for (int i = 0; i < 24; i++) begin
            k = $urandom % 3;
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            apb(1'b1, gis_pkg::GIS_OFS_DRV_LOW + 12'(4 * k), {24'h0, d});
            en <= (i != 2);
            mid = ex;
            mid[k] = d;
            ex = drv_next(ex, k, d);
            if (i == 2) begin
                repeat (3) @(posedge clock_in);
                en <= 1'b1;
            end
            #1;
            chk({8'h0, hi, mi, lo}, {8'h0, mid});
            @(posedge clock_in);
            #1;
            chk({8'h0, hi, mi, lo}, {8'h0, ex});
        end
        rdchk(gis_pkg::GIS_OFS_DRV_MID, {24'h0, ex[1]});
        done("drive");
        // edge interrupt on one unmasked pin, a second pin masked
        b = $urandom % 8;
        c = (b + 1 + $urandom % 7) % 8;
        apb(1'b1, gis_pkg::GIS_OFS_EVENT, 32'hff);
        apb(1'b1, gis_pkg::GIS_OFS_MASK, 32'(1 << b));
        level <= 8'(1 << b) | 8'(1 << c);
        repeat (5) @(posedge clock_in);
        rdchk(gis_pkg::GIS_OFS_RIS, 32'(1 << b) | 32'(1 << c));
        rdchk(gis_pkg::GIS_OFS_MSK_STAT, 32'(1 << b));
        #1;
        chk({23'h0, cirq, pirq}, {23'h0, 1'b1, 8'(1 << b)});
        apb(1'b1, gis_pkg::GIS_OFS_ICR, 32'h0);
        rdchk(gis_pkg::GIS_OFS_MSK_STAT, 32'(1 << b));
        apb(1'b1, gis_pkg::GIS_OFS_ICR, 32'(1 << b));
        rdchk(gis_pkg::GIS_OFS_RIS, 32'(1 << c));
        rdchk(gis_pkg::GIS_OFS_ICR, 32'h0);
        #1;
        chk({31'h0, cirq}, 32'h0);
        // level sensing: a clear cannot hold while the level stays
        apb(1'b1, gis_pkg::GIS_OFS_SENSE, 32'(1 << b));
        apb(1'b1, gis_pkg::GIS_OFS_ICR, 32'(1 << b));
        rdchk(gis_pkg::GIS_OFS_MSK_STAT, 32'(1 << b));
        level <= 8'(1 << c);
        repeat (4) @(posedge clock_in);
        rdchk(gis_pkg::GIS_OFS_RIS, 32'(1 << c));
        done("interrupt");
        // debug pin kept on its hardware function throughout
        d = {1'b1, 7'($urandom) | 7'h01};
        apb(1'b1, gis_pkg::GIS_OFS_FSEL, {24'h0, d});
        apb(1'b1, gis_pkg::GIS_OFS_DIR, 32'h5a);
        sw <= 8'($urandom);
        @(posedge clock_in);
        #2;
        chk({16'h0, pdo, poe}, {16'h0, (d & hwd) | (~d & sw), (d & ~hwe) | (~d & 8'ha5)});
        chk({24'h0, fsel}, {24'h0, d});
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        @(posedge clock_in);
        #1;
        chk({16'h0, fsel, dir}, 32'h8000);
        chk({8'h0, hi, mi, lo}, 32'hff);
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        rdchk(gis_pkg::GIS_OFS_FSEL, 32'h80);
        done("function");
        give_verdict();
    end
endmodule
`default_nettype wire
